// ### rtl/rsss_pkg.sv
// Constants and types for the resonant start-up supply sequencer
package rsss_pkg;
  // Synchroniser depth for comparator inputs
  localparam int unsigned SYNC_STAGES = 3;
  // Number of comparator inputs
  localparam int unsigned NUM_CMP = 8;
  // Comparator bit positions in the packed comparator vector
  localparam int unsigned CMP_MAIN_RST = 0;
  localparam int unsigned CMP_MAIN_START = 1;
  localparam int unsigned CMP_MAIN_HYS = 2;
  localparam int unsigned CMP_MAIN_LOW = 3;
  localparam int unsigned CMP_MAIN_LOW_HYS = 4;
  localparam int unsigned CMP_MAIN_STOP = 5;
  localparam int unsigned CMP_REG_UV = 6;
  localparam int unsigned CMP_REG_STOP = 7;
  // Settings readout duration, in ns
  localparam int unsigned READOUT_TIME_NS = 1000;
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned READOUT_CYCLES = (READOUT_TIME_NS + CLOCK_PERIOD_NS - 1)
                                           / CLOCK_PERIOD_NS;
  localparam int unsigned READOUT_CNT_W = 8;
  localparam logic [READOUT_CNT_W-1:0] READOUT_LAST = READOUT_CNT_W'(READOUT_CYCLES - 1);

  typedef enum logic [2:0] {
    RSSS_NO_SUPPLY,
    RSSS_READOUT,
    RSSS_WAIT_BOOST,
    RSSS_RUN,
    RSSS_PROTECT
  } rsss_state_type;
endpackage

// ### rtl/rsss_sync.sv
// Three-stage synchroniser with agreement filter for one comparator input
`timescale 1ns/1ps
module rsss_sync (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic level_o
);
  logic [rsss_pkg::SYNC_STAGES-1:0] stage;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage <= '0;
    end else begin
      stage <= {stage[rsss_pkg::SYNC_STAGES-2:0], async_i};
    end
  end

  // Stage 0 feeds only stage 1; change accepted when stages 1 and 2 agree
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_o <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_o <= stage[2];
    end
  end
endmodule

// ### rtl/rsss_sequencer.sv
// Start-up and supply sequencer of the resonant converter controller
// Behaviour
// - Below reset level keep charge current limited
// - Above reset level close start-up switch fully
// - Regulate main supply hysteretically at start level
// - Start-up source off once running on auxiliary
// - Protection mode regulates main supply to start
// - Burst idle: top up at low level
// - No switching before regulated supply UV level
// - Regulated supply undervoltage restarts start-up sequence
// - Stop level enters no-supply state, recharge both
// - Read settings after both start levels reached
// - Pull boost-sense low in no-supply and readout
// - Release boost-sense once settings defined
// - Switch only after boost start level reached
// - Low feedback current disables high-voltage charging
`timescale 1ns/1ps
module rsss_sequencer (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic main_supply_above_reset_i,
  input wire logic main_supply_above_start_i,
  input wire logic main_supply_above_start_hys_i,
  input wire logic main_supply_above_low_i,
  input wire logic main_supply_above_low_hys_i,
  input wire logic main_supply_above_stop_i,
  input wire logic regulated_supply_above_uv_i,
  input wire logic regulated_supply_above_stop_i,
  input wire logic boost_sense_above_start_i,
  input wire logic feedback_below_regulation_i,
  input wire logic protection_request_i,
  input wire logic burst_idle_i,
  output logic hv_switch_on_o,
  output logic hv_current_limit_o,
  output logic boost_sense_pull_low_oe_o,
  output logic boost_sense_pull_low_o,
  output logic settings_readout_o,
  output logic half_bridge_enable_o,
  output logic [2:0] state_o
);
  logic [rsss_pkg::NUM_CMP-1:0] cmp_raw;
  logic [rsss_pkg::NUM_CMP-1:0] cmp;
  logic boost_ok;
  logic fb_low;
  logic hv_disabled;
  logic hv_on;
  logic low_on;
  logic [rsss_pkg::READOUT_CNT_W-1:0] readout_cnt;
  rsss_pkg::rsss_state_type state;
  rsss_pkg::rsss_state_type next_state;
  logic next_hv_switch;
  logic supplies_lost;

  assign cmp_raw[rsss_pkg::CMP_MAIN_RST] = main_supply_above_reset_i;
  assign cmp_raw[rsss_pkg::CMP_MAIN_START] = main_supply_above_start_i;
  assign cmp_raw[rsss_pkg::CMP_MAIN_HYS] = main_supply_above_start_hys_i;
  assign cmp_raw[rsss_pkg::CMP_MAIN_LOW] = main_supply_above_low_i;
  assign cmp_raw[rsss_pkg::CMP_MAIN_LOW_HYS] = main_supply_above_low_hys_i;
  assign cmp_raw[rsss_pkg::CMP_MAIN_STOP] = main_supply_above_stop_i;
  assign cmp_raw[rsss_pkg::CMP_REG_UV] = regulated_supply_above_uv_i;
  assign cmp_raw[rsss_pkg::CMP_REG_STOP] = regulated_supply_above_stop_i;

  // Comparators are analog and asynchronous to the clock
  for (genvar g = 0; g < rsss_pkg::NUM_CMP; g++) begin : g_sync
    rsss_sync u_sync (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .async_i(cmp_raw[g]),
      .level_o(cmp[g])
    );
  end

  rsss_sync u_sync_boost (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(boost_sense_above_start_i),
    .level_o(boost_ok)
  );

  rsss_sync u_sync_fb (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(feedback_below_regulation_i),
    .level_o(fb_low)
  );

  assign supplies_lost = !cmp[rsss_pkg::CMP_MAIN_STOP] ||
                         !cmp[rsss_pkg::CMP_REG_STOP];

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      rsss_pkg::RSSS_NO_SUPPLY: begin
        if (cmp[rsss_pkg::CMP_MAIN_START] && cmp[rsss_pkg::CMP_REG_UV]) begin
          next_state = rsss_pkg::RSSS_READOUT;
        end
      end
      rsss_pkg::RSSS_READOUT: begin
        if (readout_cnt == rsss_pkg::READOUT_LAST) begin
          next_state = rsss_pkg::RSSS_WAIT_BOOST;
        end
      end
      rsss_pkg::RSSS_WAIT_BOOST: begin
        if (boost_ok && cmp[rsss_pkg::CMP_REG_UV]) begin
          next_state = rsss_pkg::RSSS_RUN;
        end
      end
      rsss_pkg::RSSS_RUN: begin
        if (protection_request_i) begin
          next_state = rsss_pkg::RSSS_PROTECT;
        end
      end
      rsss_pkg::RSSS_PROTECT: begin
        if (!protection_request_i) begin
          next_state = rsss_pkg::RSSS_NO_SUPPLY;
        end
      end
      default: begin
        next_state = rsss_pkg::RSSS_NO_SUPPLY;
      end
    endcase
    // Undervoltage and stop levels override everything
    if (supplies_lost) begin
      next_state = rsss_pkg::RSSS_NO_SUPPLY;
    end else if (!cmp[rsss_pkg::CMP_REG_UV] && state != rsss_pkg::RSSS_NO_SUPPLY) begin
      next_state = rsss_pkg::RSSS_NO_SUPPLY;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= rsss_pkg::RSSS_NO_SUPPLY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      readout_cnt <= '0;
    end else if (state == rsss_pkg::RSSS_READOUT && next_state == rsss_pkg::RSSS_READOUT) begin
      readout_cnt <= readout_cnt + 1'b1;
    end else begin
      readout_cnt <= '0;
    end
  end

  // Once output nears regulation, aux winding takes over until restart or protection
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hv_disabled <= 1'b0;
    end else if (next_state == rsss_pkg::RSSS_NO_SUPPLY ||
                 next_state == rsss_pkg::RSSS_PROTECT) begin
      hv_disabled <= 1'b0;
    end else if (state == rsss_pkg::RSSS_RUN && fb_low) begin
      hv_disabled <= 1'b1;
    end
  end

  // Start-level hysteresis: on below start-hys, off above start
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hv_on <= 1'b1;
    end else if (cmp[rsss_pkg::CMP_MAIN_START]) begin
      hv_on <= 1'b0;
    end else if (!cmp[rsss_pkg::CMP_MAIN_HYS]) begin
      hv_on <= 1'b1;
    end
  end

  // Low-level hysteresis for burst idle top-up
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_on <= 1'b0;
    end else if (cmp[rsss_pkg::CMP_MAIN_LOW_HYS]) begin
      low_on <= 1'b0;
    end else if (!cmp[rsss_pkg::CMP_MAIN_LOW]) begin
      low_on <= 1'b1;
    end
  end

  always_comb begin
    next_hv_switch = 1'b0;
    case (state)
      rsss_pkg::RSSS_NO_SUPPLY: begin
        // Regulated supply still charging needs the switch closed
        next_hv_switch = hv_on || !cmp[rsss_pkg::CMP_REG_UV];
      end
      rsss_pkg::RSSS_READOUT,
      rsss_pkg::RSSS_WAIT_BOOST,
      rsss_pkg::RSSS_PROTECT: begin
        next_hv_switch = hv_on;
      end
      rsss_pkg::RSSS_RUN: begin
        if (!hv_disabled) begin
          next_hv_switch = hv_on;
        end else if (burst_idle_i) begin
          next_hv_switch = low_on;
        end else begin
          next_hv_switch = 1'b0;
        end
      end
      default: begin
        next_hv_switch = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hv_switch_on_o <= 1'b0;
      hv_current_limit_o <= 1'b1;
    end else begin
      hv_switch_on_o <= next_hv_switch;
      // Limits dissipation into a shorted supply capacitor
      hv_current_limit_o <= !cmp[rsss_pkg::CMP_MAIN_RST];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boost_sense_pull_low_oe_o <= 1'b1;
      boost_sense_pull_low_o <= 1'b0;
      settings_readout_o <= 1'b0;
      half_bridge_enable_o <= 1'b0;
      state_o <= 3'h0;
    end else begin
      boost_sense_pull_low_oe_o <= next_state == rsss_pkg::RSSS_NO_SUPPLY ||
                                   next_state == rsss_pkg::RSSS_READOUT;
      boost_sense_pull_low_o <= 1'b0;
      settings_readout_o <= next_state == rsss_pkg::RSSS_READOUT;
      half_bridge_enable_o <= next_state == rsss_pkg::RSSS_RUN;
      state_o <= next_state;
    end
  end
endmodule

// ### tb/rsss_sequencer_sva.sv
// Assertion checker for the start-up supply sequencer
`timescale 1ns/1ps
module rsss_sequencer_sva (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic main_supply_above_reset_i,
  input wire logic main_supply_above_start_hys_i,
  input wire logic feedback_below_regulation_i,
  input wire logic burst_idle_i,
  input wire logic hv_switch_on_o,
  input wire logic hv_current_limit_o,
  input wire logic boost_sense_pull_low_oe_o,
  input wire logic settings_readout_o,
  input wire logic half_bridge_enable_o,
  input wire logic [2:0] state_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Eight cycles cover the synchroniser and filter latency
  AST_LIMIT_LOW: assert property (!main_supply_above_reset_i [*8] |-> hv_current_limit_o)
    else $error("charge current not limited below reset level");
  AST_LIMIT_OFF: assert property (main_supply_above_reset_i [*8] |-> !hv_current_limit_o)
    else $error("charge current still limited above reset level");
  AST_RDO_LEN: assert property ($fell(settings_readout_o) && state_o == 3'h2 |-> $past(settings_readout_o, 100))
    else $error("settings readout shorter than its duration");
  AST_OE_HOLD: assert property (state_o <= 3'h1 |-> boost_sense_pull_low_oe_o)
    else $error("boost sense released too early");
  AST_RELEASE: assert property (state_o == 3'h2 |-> !boost_sense_pull_low_oe_o)
    else $error("boost sense not released after readout");
  AST_HB_RUN: assert property (half_bridge_enable_o |-> state_o == 3'h3)
    else $error("half bridge enabled outside run");
  AST_HB_ROSE: assert property ($rose(half_bridge_enable_o) |-> $past(state_o) == 3'h2)
    else $error("half bridge started without boost wait");
  AST_FB_OFF: assert property ((state_o == 3'h3 && feedback_below_regulation_i && !burst_idle_i) [*8] |-> !hv_switch_on_o)
    else $error("high-voltage charging kept on near regulation");
  AST_PROT_ON: assert property ((state_o == 3'h4 && !main_supply_above_start_hys_i) [*8] |-> hv_switch_on_o)
    else $error("main supply not topped up in protection");
endmodule
bind rsss_sequencer rsss_sequencer_sva rsss_sequencer_sva_i (.clock_i, .reset_n_i,
  .main_supply_above_reset_i, .main_supply_above_start_hys_i, .feedback_below_regulation_i,
  .burst_idle_i, .hv_switch_on_o, .hv_current_limit_o, .boost_sense_pull_low_oe_o,
  .settings_readout_o, .half_bridge_enable_o, .state_o);

// ### tb/rsss_pfc_model.sv
// Companion power-factor controller as seen through the boost-sense pin
`timescale 1ns/1ps
module rsss_pfc_model #(parameter int DELAY = 20) (
  input wire logic clock_i,
  input wire logic pull_low_oe_i,
  output logic boost_above_start_o = 1'b0
);
  int cnt = 0;
  // Boost only ramps once the pin is released; a held pin keeps it down
  always @(posedge clock_i) begin
    if (pull_low_oe_i) begin
      cnt <= 0;
      boost_above_start_o <= 1'b0;
    end else begin
      cnt <= (cnt < DELAY) ? cnt + 1 : cnt;
      boost_above_start_o <= (cnt >= DELAY);
    end
  end
endmodule

// ### tb/resonant_startup_supply_sequencer_test.sv
// Self-checking bench for the start-up supply sequencer
`timescale 1ns/1ps
module resonant_startup_supply_sequencer_test;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] cmp = 8'h00;
  logic fb = 1'b0;
  logic prot = 1'b0;
  logic burst = 1'b0;
  logic boost, hv, lim, oe, pl, rdo, hb;
  logic [2:0] st;
  int fail_count = 0;
  int n_tests = 0;
  rsss_sequencer rsss_sequencer_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .main_supply_above_reset_i(cmp[0]), .main_supply_above_start_i(cmp[1]),
    .main_supply_above_start_hys_i(cmp[2]), .main_supply_above_low_i(cmp[3]),
    .main_supply_above_low_hys_i(cmp[4]), .main_supply_above_stop_i(cmp[5]),
    .regulated_supply_above_uv_i(cmp[6]), .regulated_supply_above_stop_i(cmp[7]),
    .boost_sense_above_start_i(boost), .feedback_below_regulation_i(fb),
    .protection_request_i(prot), .burst_idle_i(burst), .hv_switch_on_o(hv),
    .hv_current_limit_o(lim), .boost_sense_pull_low_oe_o(oe), .boost_sense_pull_low_o(pl),
    .settings_readout_o(rdo), .half_bridge_enable_o(hb), .state_o(st));
  rsss_pfc_model rsss_pfc_model_i (.clock_i(clock_i), .pull_low_oe_i(oe),
    .boost_above_start_o(boost));
  initial forever #5 clock_i = ~clock_i;
  task automatic check(logic [2:0] got, logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_st(logic [2:0] s, int n);
    // Step off the launching edge before the first look at the state
    #1;
    for (int i = 0; i < n && st !== s; i++) cyc(1);
    check(st, s);
  endtask
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset();
    cyc(8);
    check(lim, 1);
    check(oe, 1);
    check(pl, 0);
    check(st, 0);
    @(posedge clock_i) cmp <= 8'h01;
    cyc(8);
    check(lim, 0);
    check(hv, 1);
    $display("done: reset and charge");
  endtask
  task automatic t_start();
    @(posedge clock_i) cmp <= 8'hff;
    wait_st(1, 20);
    check(rdo, 1);
    check(oe, 1);
    // Switch opens one edge after the state, from the hysteresis register
    cyc(1);
    check(hv, 0);
    cyc(49);
    check(st, 1);
    wait_st(2, 80);
    check(oe, 0);
    check(hb, 0);
    wait_st(3, 60);
    check(hb, 1);
    $display("done: start-up");
  endtask
  task automatic t_feedback();
    // Sag first, so that the disable has a closed switch to open
    @(posedge clock_i) cmp <= 8'hf9;
    cyc(8);
    check(hv, 1);
    @(posedge clock_i) fb <= 1'b1;
    cyc(8);
    check(hv, 0);
    @(posedge clock_i) burst <= 1'b1;
    cmp <= 8'he7;
    cyc(8);
    check(hv, 1);
    @(posedge clock_i) cmp <= 8'hff;
    cyc(8);
    check(hv, 0);
    @(posedge clock_i) burst <= 1'b0;
    fb <= 1'b0;
    $display("done: feedback and burst");
  endtask
  task automatic t_protect();
    @(posedge clock_i) prot <= 1'b1;
    wait_st(4, 10);
    check(hb, 0);
    @(posedge clock_i) cmp <= 8'hf9;
    cyc(8);
    check(hv, 1);
    @(posedge clock_i) cmp <= 8'hff;
    cyc(8);
    check(hv, 0);
    @(posedge clock_i) prot <= 1'b0;
    wait_st(0, 10);
    $display("done: protection");
  endtask
  task automatic t_loss();
    @(posedge clock_i) cmp <= 8'hbf;
    wait_st(0, 10);
    check(hb, 0);
    check(oe, 1);
    t_start();
    @(posedge clock_i) cmp <= 8'hdf;
    wait_st(0, 10);
    @(posedge clock_i) cmp <= 8'hff;
    wait_st(1, 20);
    @(posedge clock_i) cmp <= 8'h7f;
    wait_st(0, 10);
    check(rdo, 0);
    $display("done: supply loss");
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_start();
    t_feedback();
    t_protect();
    t_start();
    t_loss();
    final_report();
  end
  // Whole sequence needs well under 2000 cycles
  initial begin
    #50000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
